// ===== logic/rsq_sequencer.sv
// rsq_sequencer: power sequence, thermal protection and status pins.
// assumes power-ok and temperature inputs are synchronous to aclk.
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module rsq_sequencer
    import rsq_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = STEP_CYC,
    parameter int unsigned RESET_CYCLES = RESET_CYC,
    parameter int unsigned B2OFF_CYCLES = B2OFF_CYC,
    parameter int unsigned B3OFF_CYCLES = B3OFF_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rails_on_request,
    input wire logic voltage_scaling_select,
    input wire logic [7:0] die_temp,
    input wire rsq_rails_t rail_power_ok,
    input wire logic storage_in_reg,
    output rsq_rails_t rail_enable,
    output logic [7:0] buck2_setpoint,
    output logic external_rail_enable_oe,
    output logic system_reset_out_n_oe,
    output logic interrupt_request_n_oe,
    output logic storage_power_ok_oe,
    output logic deep_sleep_state
);
    typedef struct packed {
        rsq_state_t st;
        logic [31:0] dly;
        logic [31:0] rst_cnt;
        logic started;
        rsq_rails_t en;
        rsq_therm_t act;
        rsq_therm_t flag;
        logic [2:0] ctrl;
        logic [7:0] primary_voltage_setpoint;
        logic [7:0] alternate_voltage_setpoint;
        logic [7:0] sp;
        logic ext_oe;
        logic rst_oe;
        logic irq_oe;
        logic str_oe;
        logic slp;
        logic aw_got;
        logic w_got;
        logic [7:0] awa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic awr;
        logic wr;
        logic bv;
        logic [1:0] br;
        logic arr;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
    } rsq_regs_t;

    rsq_regs_t q_reg;
    rsq_regs_t q_next;

    function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [31:0] d,
                                              input logic [3:0] s);
        lane_merge = s[0] ? d[7:0] : old;
    endfunction : lane_merge

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic sleep_req;
        logic conv_off;
        logic all_off;
        logic dly_done;
        logic b1_ctl_bad;
        logic [7:0] a;
        sleep_req = 1'b0;
        conv_off = 1'b0;
        all_off = 1'b0;
        dly_done = 1'b0;
        b1_ctl_bad = 1'b0;
        a = 8'h00;
        q_next = q_reg;
        q_next.awr = 1'b0;
        q_next.wr = 1'b0;
        q_next.arr = 1'b0;

        // --------------------------------------------------------------
        // thermal protection
        // --------------------------------------------------------------
        // thermal comparators with 15 degree hysteresis
        if (die_temp > T_WARN) q_next.act.warn = 1'b1;
        else if (die_temp <= T_WARN - T_HYST) q_next.act.warn = 1'b0;
        if (die_temp > T_CONV) q_next.act.conv = 1'b1;
        else if (die_temp <= T_CONV - T_HYST) q_next.act.conv = 1'b0;
        if (die_temp > T_TOTAL) q_next.act.total = 1'b1;
        else if (die_temp <= T_TOTAL - T_HYST) q_next.act.total = 1'b0;
        conv_off = q_reg.act.conv | q_reg.act.total;
        all_off = q_reg.act.total;

        // status read clears flags, but a live fault re-sets them: set wins
        q_next.flag = q_reg.flag | q_reg.act;

        if (rails_on_request) q_next.started = 1'b1;
        // sleep on pin low after start, or serial command when OR-select set
        sleep_req = (q_reg.started & ~rails_on_request)
                  | (q_reg.ctrl[CTRL_OR_SEL] & q_reg.ctrl[CTRL_SLEEP_CMD]);

        dly_done = (q_reg.dly == 32'd0);
        if (!dly_done) q_next.dly = q_reg.dly - 32'd1;

        // --------------------------------------------------------------
        // power sequence
        // --------------------------------------------------------------
        // a step reloads its timer while its trigger rail is not ok
        unique case (q_reg.st)
            S_IDLE: begin
                if (q_reg.started && !all_off && !q_reg.ctrl[CTRL_PWR_OFF]) begin
                    q_next.en.ldo = 1'b1;
                    q_next.en.buck1 = 1'b1;
                    q_next.en.bias = 1'b1;
                    q_next.st = S_B1;
                    q_next.dly = 32'(STEP_CYCLES);
                end
            end
            S_B1: begin
                if (!rail_power_ok.buck1) q_next.dly = 32'(STEP_CYCLES);
                else if (dly_done) begin
                    q_next.en.buck2 = 1'b1;
                    q_next.st = S_B2;
                    q_next.dly = 32'(STEP_CYCLES);
                end
            end
            S_B2: begin
                if (!rail_power_ok.buck2) q_next.dly = 32'(STEP_CYCLES);
                else if (dly_done) begin
                    q_next.en.buck4 = 1'b1;
                    q_next.st = S_B4;
                    q_next.dly = 32'(STEP_CYCLES);
                end
            end
            S_B4: begin
                if (!rail_power_ok.buck4) q_next.dly = 32'(STEP_CYCLES);
                else if (dly_done) begin
                    q_next.en.boost = 1'b1;
                    q_next.st = S_BOOST;
                    q_next.dly = 32'(STEP_CYCLES);
                end
            end
            S_BOOST: begin
                // boost soft-start is analog; we wait for its power-ok, then the STEP_CYCLES delay
                if (!rail_power_ok.boost) q_next.dly = 32'(STEP_CYCLES);
                else if (dly_done) begin
                    q_next.en.buck3 = 1'b1;
                    q_next.st = S_B3;
                end
            end
            S_B3: begin
                if (rail_power_ok.buck3) q_next.st = S_ON;
            end
            S_ON: begin
                if (sleep_req || conv_off || q_reg.ctrl[CTRL_PWR_OFF]) begin
                    q_next.st = S_OFF_B3;
                    q_next.dly = 32'(B3OFF_CYCLES);
                end
            end
            S_OFF_B3: begin
                if (dly_done) begin
                    q_next.en.buck3 = 1'b0;
                    q_next.st = S_OFF_BOOST;
                end
            end
            S_OFF_BOOST: begin
                q_next.en.boost = 1'b0;
                q_next.st = S_OFF_B4;
            end
            S_OFF_B4: begin
                // deep sleep keeps buck4 on
                if (!sleep_req || conv_off || q_reg.ctrl[CTRL_PWR_OFF])
                    q_next.en.buck4 = 1'b0;
                q_next.st = S_OFF_B2;
                q_next.dly = 32'(B2OFF_CYCLES);
            end
            S_OFF_B2: begin
                if (dly_done) begin
                    q_next.en.buck2 = 1'b0;
                    if (q_reg.en.buck4) q_next.st = S_SLEEP;
                    else q_next.st = S_OFF_B1;
                end
            end
            S_OFF_B1: begin
                if (conv_off) q_next.en.buck1 = 1'b0;
                if (all_off || q_reg.ctrl[CTRL_PWR_OFF]) begin
                    q_next.en = '0;
                    q_next.st = S_IDLE;
                end else if (!conv_off) begin
                    q_next.en = '0;
                    q_next.st = S_IDLE;
                end
            end
            S_SLEEP: begin
                if (conv_off || q_reg.ctrl[CTRL_PWR_OFF]) begin
                    q_next.st = S_OFF_B4;
                end else if (!sleep_req) begin
                    q_next.en.buck2 = 1'b1;
                    q_next.st = S_B2;
                    q_next.dly = 32'(STEP_CYCLES);
                end
            end
            default: q_next.st = S_IDLE;
        endcase
        // one exit path for any hot die, so the sequence cannot keep advancing
        if (conv_off) begin
            q_next.en.buck1 = 1'b0;
            q_next.en.buck2 = 1'b0;
            q_next.en.buck3 = 1'b0;
            q_next.en.buck4 = 1'b0;
            q_next.en.boost = 1'b0;
            q_next.en.bias = 1'b0;
            if (q_reg.st != S_IDLE && q_reg.st != S_OFF_B1) q_next.st = S_OFF_B1;
        end
        if (all_off) q_next.en = '0;
        q_next.slp = (q_next.st == S_SLEEP);

        // --------------------------------------------------------------
        // status pins
        // --------------------------------------------------------------
        // reset output: low while a controlling enabled rail is not ok
        b1_ctl_bad = q_reg.en.buck1 & ~rail_power_ok.buck1;
        if (!q_reg.en.buck1 || b1_ctl_bad) begin
            q_next.rst_cnt = 32'(RESET_CYCLES);
            q_next.rst_oe = 1'b1;
        end else if (q_reg.rst_cnt != 32'd0) begin
            q_next.rst_cnt = q_reg.rst_cnt - 32'd1;
        end else begin
            q_next.rst_oe = 1'b0;
        end

        q_next.ext_oe = ~(q_next.en.buck2 & rail_power_ok.buck2 & q_reg.en.buck2);
        q_next.irq_oe = |q_next.flag;
        q_next.str_oe = ~storage_in_reg;
        q_next.sp = voltage_scaling_select ? q_reg.alternate_voltage_setpoint : q_reg.primary_voltage_setpoint;

        // --------------------------------------------------------------
        // axi4-lite slave: address and data taken in either order
        // --------------------------------------------------------------
        if (s_axi_awvalid && !q_reg.aw_got && !q_reg.bv && !q_reg.awr) begin
            q_next.awr = 1'b1;
            q_next.aw_got = 1'b1;
            q_next.awa = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && !q_reg.w_got && !q_reg.bv && !q_reg.wr) begin
            q_next.wr = 1'b1;
            q_next.w_got = 1'b1;
            q_next.wd = s_axi_wdata;
            q_next.ws = s_axi_wstrb;
        end
        if (q_reg.aw_got && q_reg.w_got && !q_reg.bv) begin
            q_next.aw_got = 1'b0;
            q_next.w_got = 1'b0;
            q_next.bv = 1'b1;
            q_next.br = RESP_OK;
            unique case (q_reg.awa)
                CTRL_OFS: q_next.ctrl = q_reg.ws[0] ? q_reg.wd[2:0] : q_reg.ctrl;
                PRIMARY_VOLTAGE_SETPOINT_OFS: q_next.primary_voltage_setpoint = lane_merge(q_reg.primary_voltage_setpoint, q_reg.wd, q_reg.ws);
                ALTERNATE_VOLTAGE_SETPOINT_OFS: q_next.alternate_voltage_setpoint = lane_merge(q_reg.alternate_voltage_setpoint, q_reg.wd, q_reg.ws);
                STAT_OFS, TEMP_OFS, ADDR_OFS: q_next.br = RESP_OK;
                default: q_next.br = RESP_SLVERR;
            endcase
        end
        if (q_reg.bv && s_axi_bready) q_next.bv = 1'b0;

        if (s_axi_arvalid && !q_reg.rv && !q_reg.arr) begin
            q_next.arr = 1'b1;
            q_next.rv = 1'b1;
            q_next.rr = RESP_OK;
            q_next.rd = 32'h0000_0000;
            a = s_axi_araddr[7:0];
            unique case (a)
                CTRL_OFS: q_next.rd = {29'h0, q_reg.ctrl};
                STAT_OFS: begin
                    q_next.rd = {17'h0, 4'(q_reg.st), rail_power_ok, ~q_reg.rst_oe, q_reg.flag};
                    q_next.flag = q_reg.act;
                end
                PRIMARY_VOLTAGE_SETPOINT_OFS: q_next.rd = {24'h0, q_reg.primary_voltage_setpoint};
                ALTERNATE_VOLTAGE_SETPOINT_OFS: q_next.rd = {24'h0, q_reg.alternate_voltage_setpoint};
                TEMP_OFS: q_next.rd = {24'h0, die_temp};
                ADDR_OFS: q_next.rd = {17'h0, BK_ADDR, 1'b0, PM_ADDR};
                default: q_next.rr = RESP_SLVERR;
            endcase
        end
        if (q_reg.rv && s_axi_rready) q_next.rv = 1'b0;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_reg <= '0;
            q_reg.st <= S_IDLE;
            q_reg.ctrl <= CTRL_RST;
            q_reg.primary_voltage_setpoint <= PRIMARY_VOLTAGE_SETPOINT_RST;
            q_reg.alternate_voltage_setpoint <= ALTERNATE_VOLTAGE_SETPOINT_RST;
            q_reg.ext_oe <= 1'b1;
            q_reg.rst_oe <= 1'b1;
            q_reg.str_oe <= 1'b1;
        end else begin
            q_reg <= q_next;
        end
    end

    assign s_axi_awready = q_reg.awr;
    assign s_axi_wready = q_reg.wr;
    assign s_axi_bvalid = q_reg.bv;
    assign s_axi_bresp = q_reg.br;
    assign s_axi_arready = q_reg.arr;
    assign s_axi_rvalid = q_reg.rv;
    assign s_axi_rdata = q_reg.rd;
    assign s_axi_rresp = q_reg.rr;
    assign rail_enable = q_reg.en;
    assign buck2_setpoint = q_reg.sp;
    assign external_rail_enable_oe = q_reg.ext_oe;
    assign system_reset_out_n_oe = q_reg.rst_oe;
    assign interrupt_request_n_oe = q_reg.irq_oe;
    assign storage_power_ok_oe = q_reg.str_oe;
    assign deep_sleep_state = q_reg.slp;
endmodule : rsq_sequencer
`default_nettype wire

// ===== logic/rsq_pkg.sv
// rsq_pkg: constants, register map and state carriers for the rail sequencer.
// assumes one 10 MHz clock; registers sit behind an axi4-lite slave.
// What this block does
// - over 120C warning sets flag, asserts irq
// - over 145C disables converters, flag, irq
// - over 155C disables everything, flag, irq
// - resume after temperature drops 15C
// - ldo and buck1 start first, no delay
// - buck2 2ms after buck1, 2ms off-delay
// - external enable released when buck2 regulates
// - buck4 2ms after buck2, no off-delay
// - boost 2ms after buck4, long soft-start
// - buck3 last after boost, 3ms off-delay
// - system reset released 20ms after buck1
// - nothing starts before first rails-on high
// - rails-on low sleeps, high wakes again
// - select bit ORs pin and serial sleep
// - deep sleep drops buck2, buck3, boost, ext
// - scaling select picks buck2 setpoint
// - host may rewrite both setpoints
// - interrupt is active-low open drain
// - storage power-ok open drain output
// - two serial addresses 0x25 and 0x26
// - interrupt held while fault persists, read clears
// - reset low when controlling rail not ok
`default_nettype none
package rsq_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned STEP_DELAY_MS = 2;
    localparam int unsigned RESET_DELAY_MS = 20;
    localparam int unsigned BUCK2_OFF_MS = 2;
    localparam int unsigned BUCK3_OFF_MS = 3;
    localparam int unsigned STEP_CYC = STEP_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned RESET_CYC = RESET_DELAY_MS * (CLK_HZ / 1000);
    localparam int unsigned B2OFF_CYC = BUCK2_OFF_MS * (CLK_HZ / 1000);
    localparam int unsigned B3OFF_CYC = BUCK3_OFF_MS * (CLK_HZ / 1000);
    localparam logic [6:0] PM_ADDR = 7'h25;
    localparam logic [6:0] BK_ADDR = 7'h26;
    // byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] PRIMARY_VOLTAGE_SETPOINT_OFS = 8'h08;
    localparam logic [7:0] ALTERNATE_VOLTAGE_SETPOINT_OFS = 8'h0C;
    localparam logic [7:0] TEMP_OFS = 8'h10;
    localparam logic [7:0] ADDR_OFS = 8'h14;
    // control bits
    localparam int CTRL_SLEEP_CMD = 0;
    localparam int CTRL_OR_SEL = 1;
    localparam int CTRL_PWR_OFF = 2;
    localparam logic [2:0] CTRL_RST = 3'h2;
    localparam logic [7:0] PRIMARY_VOLTAGE_SETPOINT_RST = 8'h00;
    localparam logic [7:0] ALTERNATE_VOLTAGE_SETPOINT_RST = 8'h00;
    // temperature thresholds in whole degrees
    localparam logic [7:0] T_WARN = 8'h78;
    localparam logic [7:0] T_CONV = 8'h91;
    localparam logic [7:0] T_TOTAL = 8'h9B;
    localparam logic [7:0] T_HYST = 8'h0F;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {
        S_IDLE, S_B1, S_B2, S_B4, S_BOOST, S_B3, S_ON, S_SLEEP,
        S_OFF_B3, S_OFF_BOOST, S_OFF_B4, S_OFF_B2, S_OFF_B1
    } rsq_state_t;

    typedef struct packed {
        logic ldo;
        logic buck1;
        logic buck2;
        logic buck3;
        logic buck4;
        logic boost;
        logic bias;
    } rsq_rails_t;

    typedef struct packed {
        logic warn;
        logic conv;
        logic total;
    } rsq_therm_t;
endpackage : rsq_pkg
`default_nettype wire

// ===== dv/rsq_props.sv
// rsq_props: timing checks on the sequencer pins and rail enables.
// assumes one aclk domain and the small delay parameters of the bench.
`timescale 1ns/10ps
`default_nettype none
module rsq_props
    import rsq_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = 20,
    parameter int unsigned RESET_CYCLES = 100
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rails_on_request,
    input wire logic [7:0] die_temp,
    input wire rsq_rails_t rail_power_ok,
    input wire rsq_rails_t rail_enable,
    input wire logic external_rail_enable_oe,
    input wire logic system_reset_out_n_oe,
    input wire logic interrupt_request_n_oe,
    input wire logic deep_sleep_state
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------------------------------
    // helper counters, saturating so a long run cannot wrap
    // ----------------------------------------
    logic seen_on;
    logic [15:0] b1_cnt, b2_cnt, slp_cnt;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seen_on <= 1'h0;
            b1_cnt <= 16'h0000;
            b2_cnt <= 16'h0000;
            slp_cnt <= 16'h0000;
        end else begin
            seen_on <= seen_on | rails_on_request;
            b1_cnt <= (rail_enable.buck1 && rail_power_ok.buck1)
                ? b1_cnt + 16'(~&b1_cnt) : 16'h0000;
            b2_cnt <= (rail_enable.buck2 && rail_power_ok.buck2)
                ? b2_cnt + 16'(~&b2_cnt) : 16'h0000;
            slp_cnt <= deep_sleep_state ? slp_cnt + 16'(~&slp_cnt) : 16'h0000;
        end
    end
    chk_warn_irq: assert property ($rose(die_temp > T_WARN)
        |-> ##[1:4] interrupt_request_n_oe)
        else $error("irq not asserted on warning");
    chk_conv_off: assert property ((die_temp > T_CONV)[*4] |-> {rail_enable.buck1,
        rail_enable.buck2, rail_enable.buck3, rail_enable.buck4, rail_enable.boost} == 5'h00)
        else $error("converter left on when hot");
    chk_total_off: assert property ((die_temp > T_TOTAL)[*4] |-> rail_enable == 7'h00)
        else $error("rail left on at shutdown");
    chk_start_gate: assert property (!seen_on |-> rail_enable == 7'h00)
        else $error("rail enabled before rails-on");
    chk_sleep_rails: assert property (slp_cnt == 16'h00C8 |-> rail_enable == 7'h65
        && external_rail_enable_oe)
        else $error("wrong rails in deep sleep");
    chk_ext_prompt: assert property ($rose(rail_enable.buck2 && rail_power_ok.buck2)
        |-> ##[1:3] !external_rail_enable_oe)
        else $error("external enable not released");
    chk_step_gap: assert property ($rose(rail_enable.buck4) |-> b2_cnt >= STEP_CYCLES)
        else $error("buck4 started early");
    chk_reset_delay: assert property ($fell(system_reset_out_n_oe)
        |-> b1_cnt >= RESET_CYCLES)
        else $error("reset released early");
    chk_reset_gate: assert property ((rail_enable.buck1 && !rail_power_ok.buck1)[*2]
        |-> system_reset_out_n_oe)
        else $error("reset released with buck1 not ok");
endmodule : rsq_props
bind rsq_sequencer rsq_props #(.STEP_CYCLES(STEP_CYCLES), .RESET_CYCLES(RESET_CYCLES)) u_props (.*);
`default_nettype wire

// ===== dv/rsq_rail_model.sv
// rsq_rail_model: power-ok of each rail as its converter would report it.
// assumes enables change on aclk; slow stretches the ramp fourfold.
`timescale 1ns/10ps
`default_nettype none
module rsq_rail_model
    import rsq_pkg::*;
#(
    parameter int unsigned LAT = 8
) (
    input wire logic aclk,
    input wire rsq_rails_t en,
    input wire logic drop_b1,
    input wire logic slow,
    output var rsq_rails_t ok
);
    // ----------------------------------------
    // ramp counters
    // ----------------------------------------
    logic [6:0][7:0] ramp;
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 7; i++) begin
            ramp[i] <= en[i] ? ramp[i] + 8'(ramp[i] != 8'hFF) : 8'h00;
        end
    end
    // low while enabled and ramping, and buck1 also while enabled with drop_b1 set; a disabled rail reads ok
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            ok[i] = !en[i] || (ramp[i] >= (slow ? LAT * 4 : LAT));
        end
        ok.buck1 = ok.buck1 && !(drop_b1 && en.buck1);
    end
endmodule : rsq_rail_model
`default_nettype wire

// ===== dv/rsq_sequencer_bench.sv
// rsq_sequencer_bench: drives pins and axi4-lite, checks pins and registers.
// assumes the rail model supplies power-ok; delays shortened by parameters.
`timescale 1ns/10ps
`default_nettype none
`define CK(x, y) begin checks_done++; if ((x) !== (y)) begin fail_count++; \
    $display("[ERR] %0t got %h want %h", $time, x, y); end end
`define WT(c) begin int k; for (k = 0; k < 2000 && !(c); k++) @(posedge aclk); `CK(c, 1'h1) end
module rsq_sequencer_bench;
    import rsq_pkg::*;
    int fail_count = 0, checks_done = 0;
    logic aclk = 1'h0, aresetn = 1'h0, drop_b1 = 1'h0, slow = 1'h0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, external_rail_enable_oe, system_reset_out_n_oe, interrupt_request_n_oe;
    logic rails_on_request = 1'h0, voltage_scaling_select = 1'h0, storage_in_reg = 1'h0;
    logic storage_power_ok_oe, deep_sleep_state;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] die_temp = 8'h19, buck2_setpoint;
    rsq_rails_t rail_power_ok, rail_enable;
    initial forever #50 aclk = ~aclk;
    rsq_sequencer #(.STEP_CYCLES(20), .RESET_CYCLES(100), .B2OFF_CYCLES(20), .B3OFF_CYCLES(30))
        i_dut (.*);
    rsq_rail_model #(.LAT(8)) i_rails (.aclk(aclk), .en(rail_enable), .drop_b1(drop_b1),
        .slow(slow), .ok(rail_power_ok));
    // ----------------------------------------
    // bus tasks and closing
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        `CK({s_axi_bvalid, s_axi_bresp}, {1'h1, e})
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [1:0] e);
        int n;
        @(posedge aclk);
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        s_axi_rready <= 1'h0;
        `CK({s_axi_rvalid, s_axi_rresp}, {1'h1, e})
    endtask : rd
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (30000) @(posedge aclk);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test;
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        `CK({external_rail_enable_oe, system_reset_out_n_oe}, 2'h3)
        `CK(interrupt_request_n_oe, 1'h0)
        `CK(storage_power_ok_oe, 1'h1)
        rd(CTRL_OFS, RESP_OK);
        `CK(d[2:0], CTRL_RST)
        rd(ADDR_OFS, RESP_OK);
        `CK(d[14:0], {BK_ADDR, 1'h0, PM_ADDR})
        rd(8'h40, RESP_SLVERR);
        wr(8'h40, 32'h0, RESP_SLVERR);
        repeat (30) @(posedge aclk);
        `CK(rail_enable, 7'h00)
        $display("test reset done");
        rails_on_request <= 1'h1;
        repeat (3) @(posedge aclk);
        `CK({rail_enable.ldo, rail_enable.buck1, rail_enable.buck2}, 3'h6)
        `WT(rail_enable.buck3);
        `WT(!system_reset_out_n_oe);
        `CK({rail_enable, external_rail_enable_oe}, 8'hFE)
        $display("test power-up done");
        wr(PRIMARY_VOLTAGE_SETPOINT_OFS, 32'h33, RESP_OK);
        wr(ALTERNATE_VOLTAGE_SETPOINT_OFS, 32'h25, RESP_OK);
        repeat (2) @(posedge aclk);
        `CK(buck2_setpoint, 8'h33)
        voltage_scaling_select <= 1'h1;
        repeat (2) @(posedge aclk);
        `CK(buck2_setpoint, 8'h25)
        wr(ALTERNATE_VOLTAGE_SETPOINT_OFS, 32'h19, RESP_OK);
        storage_in_reg <= 1'h1;
        repeat (2) @(posedge aclk);
        `CK({buck2_setpoint, storage_power_ok_oe}, 9'h032)
        $display("test pins done");
        slow <= 1'h1;
        rails_on_request <= 1'h0;
        `WT(deep_sleep_state);
        repeat (250) @(posedge aclk);
        `CK({rail_enable, external_rail_enable_oe}, 8'hCB)
        rails_on_request <= 1'h1;
        `WT(rail_enable.buck3);
        `CK(external_rail_enable_oe, 1'h0)
        slow <= 1'h0;
        wr(CTRL_OFS, 32'h3, RESP_OK);
        `WT(deep_sleep_state);
        wr(CTRL_OFS, 32'h2, RESP_OK);
        `WT(rail_enable.buck3);
        wr(CTRL_OFS, 32'h1, RESP_OK);
        repeat (60) @(posedge aclk);
        `CK({deep_sleep_state, rail_enable.buck3}, 2'h1)
        $display("test sleep done");
        die_temp <= 8'h79;
        `WT(interrupt_request_n_oe);
        rd(STAT_OFS, RESP_OK);
        `CK(d[2:0], 3'h4)
        die_temp <= 8'h92;
        `WT(!rail_enable.buck1);
        repeat (5) @(posedge aclk);
        `CK({rail_enable.ldo, rail_enable.buck3, rail_enable.boost}, 3'h4)
        die_temp <= 8'h9C;
        `WT(rail_enable == 7'h00);
        rd(STAT_OFS, RESP_OK);
        `CK(d[2:0], 3'h7)
        die_temp <= 8'h8D;
        repeat (20) @(posedge aclk);
        `CK(rail_enable.ldo, 1'h0)
        die_temp <= 8'h8C;
        repeat (40) @(posedge aclk);
        `CK({rail_enable.ldo, rail_enable.buck1}, 2'h2)
        die_temp <= 8'h19;
        `WT(rail_enable.buck3);
        `CK(interrupt_request_n_oe, 1'h1)
        rd(STAT_OFS, RESP_OK);
        repeat (3) @(posedge aclk);
        `CK(interrupt_request_n_oe, 1'h0)
        $display("test thermal done");
        `CK(system_reset_out_n_oe, 1'h0)
        drop_b1 <= 1'h1;
        repeat (4) @(posedge aclk);
        `CK(system_reset_out_n_oe, 1'h1)
        drop_b1 <= 1'h0;
        wr(CTRL_OFS, 32'h6, RESP_OK);
        `WT(!rail_enable.buck3);
        `CK(rail_enable.buck2, 1'h1)
        `WT(!rail_enable.buck2);
        `CK({rail_enable.buck3, rail_enable.boost, rail_enable.buck4}, 3'h0)
        $display("test power-off done");
        end_of_test;
    end
endmodule : rsq_sequencer_bench
`default_nettype wire
